// ---- verilog/eit_timer.sv ----
`timescale 1ns/1ps

// Behaviour
// (R1) compare register checked against counter continuously
// (R2) compare accepts any byte value
// (R3) compare not initialised by reset
// (R4) counter readable, returns current count
// (R5) reset clears counter to zero
// (R6) reset clears control; bit and byte writes
// (R7) enable low holds counter zero
// (R8) select picks divide by 64/256/1024/65536
// (R9) software writes zero to unused control bits
// (R10) match clears counter, counting continues
// (R11) interrupt in same cycle counter clears
// (R12) interrupt period is compare plus one ticks
// (R13) software writes control only when stopped
// (R14) compare change while running may match early
// (R15) set enable in separate write after select
// (R16) first interval up to one tick short
// (R17) counter steps by one per count tick
module eit_timer (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // register access
   input wire eit_pkg::eit_req_t REG_REQ,
   output logic [7:0] REG_RDATA,
   // interrupt
   output logic MATCH_IRQ
);

   logic [7:0] timer_control_q;
   logic [7:0] timer_control_d;
   logic [7:0] interval_compare_q;
   logic [7:0] interval_counter_q;
   logic [7:0] interval_counter_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic irq_q;
   logic irq_d;
   logic run_enable;
   logic count_tick;
   logic match;
   logic sel_control;
   logic sel_compare;
   logic sel_counter;
   eit_pkg::eit_clk_sel_t clk_sel;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign sel_control = REG_REQ.addr == eit_pkg::ADDR_TIMER_CONTROL;
   assign sel_compare = REG_REQ.addr == eit_pkg::ADDR_INTERVAL_COMPARE;
   assign sel_counter = REG_REQ.addr == eit_pkg::ADDR_INTERVAL_COUNTER;

   // ----------------------------------------------------------------
   // timer_control: byte write or single-bit write
   // ----------------------------------------------------------------
   always_comb begin
      timer_control_d = timer_control_q;
      if (sel_control && REG_REQ.wr) begin
         timer_control_d = REG_REQ.wdata & eit_pkg::CONTROL_WRITE_MASK; // [R6]
      end else if (sel_control && REG_REQ.bit_wr) begin
         timer_control_d[REG_REQ.bit_sel] = REG_REQ.bit_val; // [R6]
         timer_control_d = timer_control_d & eit_pkg::CONTROL_WRITE_MASK;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         timer_control_q <= eit_pkg::CONTROL_RESET; // [R6]
      end else begin
         timer_control_q <= timer_control_d;
      end
   end

   assign run_enable = timer_control_q[eit_pkg::RUN_ENABLE_BIT];
   assign clk_sel = eit_pkg::eit_clk_sel_t'({
      timer_control_q[eit_pkg::CLOCK_SELECT_HI_BIT],
      timer_control_q[eit_pkg::CLOCK_SELECT_LO_BIT]}); // [R8]

   // ----------------------------------------------------------------
   // interval_compare: byte write only, no reset
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (sel_compare && REG_REQ.wr) begin
         interval_compare_q <= REG_REQ.wdata; // [R2] [R3] [R14]
      end
   end

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   eit_prescaler u_prescaler (
      .clk(CORE_CLK),
      .srst(SRST),
      .sel(clk_sel),
      .tick(count_tick)
   );

   // ----------------------------------------------------------------
   // counter and match
   // ----------------------------------------------------------------
   assign match = interval_counter_q == interval_compare_q; // [R1]

   always_comb begin
      interval_counter_d = interval_counter_q;
      irq_d = 1'b0;
      if (!run_enable) begin
         interval_counter_d = eit_pkg::COUNTER_RESET; // [R7]
      end else if (count_tick) begin
         if (match) begin
            interval_counter_d = eit_pkg::COUNTER_RESET; // [R10] [R12]
            irq_d = 1'b1; // [R11]
         end else begin
            interval_counter_d = interval_counter_q + 8'h01; // [R17]
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         interval_counter_q <= eit_pkg::COUNTER_RESET; // [R5]
      end else begin
         interval_counter_q <= interval_counter_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d; // [R11]
      end
   end

   assign MATCH_IRQ = irq_q;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      if (REG_REQ.rd) begin
         if (sel_counter) begin
            rdata_d = interval_counter_q; // [R4]
         end else if (sel_control) begin
            rdata_d = timer_control_q;
         end else begin
            rdata_d = eit_pkg::READ_ZERO;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         rdata_q <= eit_pkg::READ_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;

endmodule : eit_timer

// ---- shared/eit_pkg.sv ----
package eit_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_TIMER_CONTROL = 16'hFFCC;
   localparam logic [15:0] ADDR_INTERVAL_COMPARE = 16'hFFCD;
   localparam logic [15:0] ADDR_INTERVAL_COUNTER = 16'hFFCE;

   // ----------------------------------------------------------------
   // timer_control fields and reset values
   // ----------------------------------------------------------------
   localparam int RUN_ENABLE_BIT = 7;
   localparam int CLOCK_SELECT_HI_BIT = 2;
   localparam int CLOCK_SELECT_LO_BIT = 1;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'h86;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // prescaler: divider bit whose rising edge is the count clock
   // ----------------------------------------------------------------
   localparam int DIV_WIDTH = 16;
   localparam logic [3:0] DIV_TAP_64 = 4'h5;
   localparam logic [3:0] DIV_TAP_256 = 4'h7;
   localparam logic [3:0] DIV_TAP_1024 = 4'h9;
   localparam logic [3:0] DIV_TAP_65536 = 4'hF;
   localparam logic [15:0] DIV_RESET = 16'h0000;

   typedef enum logic [1:0] {
      EIT_DIV_64 = 2'b00,
      EIT_DIV_256 = 2'b01,
      EIT_DIV_1024 = 2'b10,
      EIT_DIV_65536 = 2'b11
   } eit_clk_sel_t;

   // ----------------------------------------------------------------
   // register access request from the cpu side
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic bit_val;
      logic [7:0] wdata;
      logic rd;
   } eit_req_t;

endpackage : eit_pkg

// ---- verilog/eit_prescaler.sv ----
`timescale 1ns/1ps

module eit_prescaler (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // count clock selection
   input wire eit_pkg::eit_clk_sel_t sel,
   // one-cycle count clock edge
   output logic tick
);

   logic [15:0] div_q;
   logic tap_prev_q;
   logic tap;

   // ----------------------------------------------------------------
   // free-running divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         div_q <= eit_pkg::DIV_RESET;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   always_comb begin
      case (sel)
         eit_pkg::EIT_DIV_64: tap = div_q[eit_pkg::DIV_TAP_64];
         eit_pkg::EIT_DIV_256: tap = div_q[eit_pkg::DIV_TAP_256];
         eit_pkg::EIT_DIV_1024: tap = div_q[eit_pkg::DIV_TAP_1024];
         eit_pkg::EIT_DIV_65536: tap = div_q[eit_pkg::DIV_TAP_65536];
         default: tap = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // rising edge of the selected tap
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         tap_prev_q <= 1'b0;
      end else begin
         tap_prev_q <= tap;
      end
   end

   // divider runs regardless of enable, so first interval may be short
   assign tick = tap & ~tap_prev_q; // [R8] [R16]

endmodule : eit_prescaler

// ---- tb/eit_timer_chk.sv ----
`timescale 1ns/1ps

module eit_timer_chk (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic SRST,
   // register side and interrupt
   input wire eit_pkg::eit_req_t REG_REQ,
   input wire logic [7:0] REG_RDATA,
   input wire logic MATCH_IRQ
);
   localparam logic [15:0] CTL = eit_pkg::ADDR_TIMER_CONTROL;
   localparam logic [15:0] CNT = eit_pkg::ADDR_INTERVAL_COUNTER;
   logic [7:0] ctl_q;
   logic rd;
   logic on;
   assign rd = REG_REQ.rd && !REG_REQ.wr;
   assign on = ctl_q[7];
   // ----
   // shadow of the control register
   // ----
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         ctl_q <= 8'h00;
      end else if (REG_REQ.addr == CTL && REG_REQ.wr) begin
         ctl_q <= REG_REQ.wdata & 8'h86;
      end else if (REG_REQ.addr == CTL && REG_REQ.bit_wr) begin
         ctl_q <= ((ctl_q & ~(8'h01 << REG_REQ.bit_sel)) |
            ({7'h00, REG_REQ.bit_val} << REG_REQ.bit_sel)) & 8'h86;
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   property p_rst;
      disable iff (1'b0) SRST |=> REG_RDATA == 8'h00 && !MATCH_IRQ;
   endproperty
   a_rst: assert property (p_rst) else $error("reset value");
   property p_pulse; MATCH_IRQ |=> !MATCH_IRQ; endproperty
   a_pulse: assert property (p_pulse) else $error("irq width");
   property p_gap; MATCH_IRQ |=> !MATCH_IRQ [*8]; endproperty
   a_gap: assert property (p_gap) else $error("irq too soon");
   property p_hold; !REG_REQ.rd |=> $stable(REG_RDATA); endproperty
   a_hold: assert property (p_hold) else $error("rdata moved");
   property p_off; !on [*2] |-> !MATCH_IRQ; endproperty
   a_off: assert property (p_off) else $error("irq when off");
   property p_cnt0;
      !on [*2] ##0 rd && REG_REQ.addr == CNT |=> REG_RDATA == 8'h00;
   endproperty
   a_cnt0: assert property (p_cnt0) else $error("count when off");
   property p_ctl; rd && REG_REQ.addr == CTL |=> REG_RDATA == $past(ctl_q);
   endproperty
   a_ctl: assert property (p_ctl) else $error("control read");
   property p_unm;
      rd && REG_REQ.addr != CTL && REG_REQ.addr != CNT |=> REG_RDATA == 8'h00;
   endproperty
   a_unm: assert property (p_unm) else $error("nonzero read");
   c_irq: cover property (MATCH_IRQ);
   c_cnt: cover property (rd && REG_REQ.addr == CNT ##1 REG_RDATA != 8'h00);
   c_ctl: cover property (rd && REG_REQ.addr == CTL ##1 REG_RDATA != 8'h00);
endmodule : eit_timer_chk

bind eit_timer eit_timer_chk i_chk (
   .CORE_CLK(CORE_CLK),
   .SRST(SRST),
   .REG_REQ(REG_REQ),
   .REG_RDATA(REG_RDATA),
   .MATCH_IRQ(MATCH_IRQ)
);

// ---- tb/tb_eit_timer.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end

module tb_eit_timer;
   localparam logic [15:0] CTL = eit_pkg::ADDR_TIMER_CONTROL;
   localparam logic [15:0] CMP = eit_pkg::ADDR_INTERVAL_COMPARE;
   localparam logic [15:0] CNT = eit_pkg::ADDR_INTERVAL_COUNTER;
   logic clk = 1'b0;
   logic srst = 1'b1;
   eit_pkg::eit_req_t req = '0;
   logic [7:0] rdata;
   logic irq;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   eit_timer i_dut (
      .CORE_CLK(clk),
      .SRST(srst),
      .REG_REQ(req),
      .REG_RDATA(rdata),
      .MATCH_IRQ(irq)
   );
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ----
   // access tasks, k is {wr, bit_wr, rd}, bit write uses d[7] and d[2:0]
   // ----
   task automatic op(input logic [15:0] a, input logic [2:0] k,
                     input logic [7:0] d);
      @(posedge clk);
      req.addr <= a;
      {req.wr, req.bit_wr, req.rd} <= k;
      req.wdata <= d;
      req.bit_sel <= d[2:0];
      req.bit_val <= d[7];
      @(posedge clk);
      {req.wr, req.bit_wr, req.rd} <= 3'b000;
      #1;
   endtask : op
   task automatic wirq(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== 1'b1 && n < lim);
   endtask : wirq
   task automatic run(input logic [1:0] s, input logic [7:0] v);
      op(CTL, 3'b010, 8'h07);
      op(CTL, 3'b100, {5'h00, s, 1'b0});
      op(CMP, 3'b100, v);
      op(CTL, 3'b010, 8'h87);
      wirq(70000);
   endtask : run
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      op(CTL, 3'b001, 8'h00);
      `CHK(rdata, 8'h00)
      op(CNT, 3'b001, 8'h00);
      `CHK(rdata, 8'h00)
      op(CTL, 3'b100, 8'h86);
      op(CTL, 3'b001, 8'h00);
      `CHK(rdata, 8'h86)
      op(CTL, 3'b010, 8'h07);
      op(CTL, 3'b001, 8'h00);
      `CHK(rdata, 8'h06)
      op(CTL, 3'b010, 8'h01);
      op(CTL, 3'b001, 8'h00);
      `CHK(rdata, 8'h04)
      op(16'hFFCF, 3'b001, 8'h00);
      `CHK(rdata, 8'h00)
      for (int s = 0; s < 3; s++) begin
         run(s[1:0], 8'h01);
         wirq(70000);
         `CHK(n, 2 << (6 + 2 * s))
      end
      run(2'b00, 8'hFF);
      op(CNT, 3'b001, 8'h00);
      `CHK(rdata, 8'h00)
      repeat (220) @(posedge clk);
      op(CNT, 3'b001, 8'h00);
      `CHK(rdata, 8'h03)
      op(CTL, 3'b010, 8'h07);
      op(CNT, 3'b001, 8'h00);
      `CHK(rdata, 8'h00)
      wirq(300);
      `CHK(n, 300)
      end_sim();
   end
endmodule : tb_eit_timer
